// [ccs_pkg.sv]
// package: register map, field positions, modes and timing for the can control block
package ccs_pkg;
  // register offsets (word index on the plain port)
  localparam logic [3:0] ADDR_CTRL1 = 4'h0;
  localparam logic [3:0] ADDR_CTRL2 = 4'h1;
  localparam logic [3:0] ADDR_VEC = 4'h2;
  localparam logic [3:0] ADDR_FCTRL = 4'h3;
  localparam logic [3:0] ADDR_FIFO = 4'h4;
  localparam logic [3:0] ADDR_INTF = 4'h5;
  localparam logic [3:0] ADDR_INTE = 4'h6;
  localparam logic [3:0] ADDR_INTCLR = 4'h7;
  // control one field positions
  localparam int BIT_STOP_IDLE = 13;
  localparam int BIT_ABORT = 12;
  localparam int BIT_CLK_SEL = 11;
  localparam int POS_REQ = 8;
  localparam int POS_REP = 5;
  localparam int BIT_CAPTURE = 3;
  localparam int BIT_WINDOW = 0;
  // error state, flag, vector and fifo field positions, masks and limits
  localparam int BIT_TX_OFF = 13;
  localparam int POS_INTF_FLAGS = 0;
  localparam int POS_HIT_NUM = 8;
  localparam int POS_FIFO_START = 0;
  localparam int POS_WR_PTR = 8;
  localparam logic [15:0] CTRL1_RW_MASK = 16'h3f09;
  localparam logic [7:0] FLAG_MASK = 8'hef;
  localparam logic [4:0] CMP_COUNT_MAX = 5'h11;
  localparam logic [4:0] HIT_MAX = 5'h0f;
  // flag bit numbers
  localparam int F_TB = 0;
  localparam int F_RX_BUF = 1;
  localparam int F_OVF = 2;
  localparam int F_FIFO = 3;
  localparam int F_ERR = 5;
  localparam int F_WAK = 6;
  localparam int F_IVR = 7;
  // interrupt source codes
  localparam logic [6:0] IC_NONE = 7'h40;
  localparam logic [6:0] IC_ERR = 7'h41;
  localparam logic [6:0] IC_WAK = 7'h42;
  localparam logic [6:0] IC_OVF = 7'h43;
  localparam logic [6:0] IC_FIFO = 7'h44;
  // bus idle: recessive bits needed before a mode change
  localparam logic [3:0] IDLE_BITS = 4'hb;
  typedef enum logic [2:0] {
    CCS_NORMAL = 3'h0,
    CCS_DISABLE = 3'h1,
    CCS_LOOP = 3'h2,
    CCS_LISTEN = 3'h3,
    CCS_CONFIG = 3'h4,
    CCS_RSV5 = 3'h5,
    CCS_RSV6 = 3'h6,
    CCS_LISTEN_ALL = 3'h7
  } ccs_mode_t;
  // event inputs from the protocol engine
  typedef struct packed {
    logic invalid_msg;
    logic wake;
    logic error;
    logic fifo_almost_full;
    logic rx_overflow;
    logic rx_done;
    logic tx_done;
    logic [3:0] rx_buf;
    logic [2:0] tx_buf;
  } ccs_evt_t;
  // error state inputs
  typedef struct packed {
    logic tx_off;
    logic tx_passive;
    logic rx_passive;
    logic tx_warn;
    logic rx_warn;
  } ccs_err_t;
endpackage

// [ccs_sync.sv]
// three-flop synchroniser with agreement filter for pin inputs
`timescale 1ns/1ps
`default_nettype none
module ccs_sync (
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic async_i,
  output logic level_o
);
  logic s1, s2, s3, level;
  logic next_level;
  // update the filtered level once the two later stages agree
  always_comb begin
    next_level = level;
    if (s2 == s3) begin
      next_level = s2;
    end
  end
  // recessive (high) after reset
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s1 <= 1'b1;
      s2 <= 1'b1;
      s3 <= 1'b1;
      level <= 1'b1;
    end else begin
      s1 <= async_i;
      s2 <= s1;
      s3 <= s2;
      level <= next_level;
    end
  end
  assign level_o = level;
endmodule
`default_nettype wire

// [ccs_ctrl.sv]
// control, status and interrupt logic of the can controller
//
// Contract
// - loopback ties internal tx to internal rx
// - loopback releases tx and rx pins
// - stop-in-idle halts module in chip idle
// - abort-all signals buffers, self-clears when done
// - clock select one picks instruction clock
// - mode request codes, reserved ones ignored
// - mode report shows active mode, resets configuration
// - mode change waits for eleven recessive bits
// - capture enable pulses capture on receive
// - window select maps filters or buffers
// - compare count limited to valid codes
// - filter hit reports matching filter 0-15
// - interrupt code identifies pending source other than invalid message
// - fifo start selects first fifo buffer
// - request only when flag and enable set
`timescale 1ns/1ps
`default_nettype none
module ccs_ctrl (
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic [3:0] addr_i,
  input wire logic [15:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [15:0] rdata_o,
  input wire logic rx_pin_i,
  input wire logic core_tx_i,
  output logic core_rx_o,
  output logic tx_pin_o,
  output logic tx_pin_oe_n_o,
  output logic pins_to_port_o,
  input wire logic bit_tick_i,
  input wire logic chip_idle_i,
  output logic module_run_o,
  output logic abort_req_o,
  input wire logic abort_done_i,
  output logic clk_sel_instr_o,
  output logic window_filter_o,
  output logic [4:0] cmp_count_o,
  input wire logic [4:0] cmp_count_set_i,
  input wire logic cmp_count_load_i,
  output logic [4:0] fifo_start_o,
  output logic [2:0] buf_count_o,
  input wire logic [4:0] filter_hit_i,
  input wire logic [5:0] fifo_wptr_i,
  input wire logic [5:0] fifo_rptr_i,
  input wire ccs_pkg::ccs_err_t err_i,
  input wire ccs_pkg::ccs_evt_t evt_i,
  output logic capture_o,
  output ccs_pkg::ccs_mode_t mode_o,
  output logic irq_o
);
  // filtered bus level
  logic rx_sync;
  ccs_sync u_sync (
    .ref_clk_i(ref_clk_i),
    .rst_n_i(rst_n_i),
    .async_i(rx_pin_i),
    .level_o(rx_sync)
  );

  // register state
  logic stop_idle, abort_all, clk_sel, capture_en, win_sel;
  logic [2:0] mode_request;
  ccs_pkg::ccs_mode_t mode_report;
  logic [3:0] idle_cnt;
  logic [4:0] cmp_count, fifo_start, filter_hit;
  logic [2:0] buf_count;
  logic [7:0] flags, enables;
  logic [6:0] last_code;
  logic [15:0] rdata;
  logic capture;
  logic next_stop_idle, next_abort_all, next_clk_sel, next_capture_en, next_win_sel;
  logic [2:0] next_mode_request;
  ccs_pkg::ccs_mode_t next_mode_report;
  logic [3:0] next_idle_cnt;
  logic [4:0] next_cmp_count, next_fifo_start, next_filter_hit;
  logic [2:0] next_buf_count;
  logic [7:0] next_flags, next_enables, evt_set;
  logic [6:0] next_last_code, int_code;
  logic [15:0] next_rdata;
  logic next_capture, loop_on, bus_idle, halted;

  // reserved request codes are not stored
  function automatic logic req_ok(input logic [2:0] c);
    req_ok = (c != 3'h5) && (c != 3'h6);
  endfunction

  // priority encoder of pending enabled sources
  function automatic logic [6:0] code_of(input logic [7:0] p, input logic [6:0] buf_code);
    if (p[ccs_pkg::F_ERR]) begin
      code_of = ccs_pkg::IC_ERR;
    end else if (p[ccs_pkg::F_WAK]) begin
      code_of = ccs_pkg::IC_WAK;
    end else if (p[ccs_pkg::F_OVF]) begin
      code_of = ccs_pkg::IC_OVF;
    end else if (p[ccs_pkg::F_FIFO]) begin
      code_of = ccs_pkg::IC_FIFO;
    end else if (p[ccs_pkg::F_RX_BUF] || p[ccs_pkg::F_TB]) begin
      code_of = buf_code;
    end else begin
      code_of = ccs_pkg::IC_NONE;
    end
  endfunction

  assign loop_on = (mode_report == ccs_pkg::CCS_LOOP);
  assign bus_idle = (idle_cnt == ccs_pkg::IDLE_BITS);
  assign halted = stop_idle && chip_idle_i;
  // loopback path and pin release
  assign core_rx_o = loop_on ? core_tx_i : rx_sync;
  assign pins_to_port_o = loop_on || (mode_report == ccs_pkg::CCS_DISABLE);
  assign tx_pin_o = core_tx_i;
  assign tx_pin_oe_n_o = pins_to_port_o || (mode_report == ccs_pkg::CCS_LISTEN) ||
                         (mode_report == ccs_pkg::CCS_CONFIG);
  assign int_code = code_of(flags & enables, last_code);

  // control register next state
  always_comb begin
    next_stop_idle = stop_idle;
    next_abort_all = abort_all;
    next_clk_sel = clk_sel;
    next_capture_en = capture_en;
    next_win_sel = win_sel;
    next_mode_request = mode_request;
    next_mode_report = mode_report;
    next_idle_cnt = idle_cnt;
    next_cmp_count = cmp_count;
    next_fifo_start = fifo_start;
    next_buf_count = buf_count;
    next_filter_hit = filter_hit;
    // a done report clears abort first, so a fresh abort write still wins
    if (abort_all && abort_done_i) begin
      next_abort_all = 1'b0;
    end
    if (wr_i && addr_i == ccs_pkg::ADDR_CTRL1) begin
      next_stop_idle = wdata_i[ccs_pkg::BIT_STOP_IDLE];
      next_abort_all = next_abort_all | wdata_i[ccs_pkg::BIT_ABORT];
      next_clk_sel = wdata_i[ccs_pkg::BIT_CLK_SEL];
      if (req_ok(wdata_i[ccs_pkg::POS_REQ +: 3])) begin
        next_mode_request = wdata_i[ccs_pkg::POS_REQ +: 3];
      end
      next_capture_en = wdata_i[ccs_pkg::BIT_CAPTURE];
      next_win_sel = wdata_i[ccs_pkg::BIT_WINDOW];
    end
    if (wr_i && addr_i == ccs_pkg::ADDR_FCTRL) begin
      next_fifo_start = wdata_i[ccs_pkg::POS_FIFO_START +: 5];
      next_buf_count = wdata_i[15:13];
    end
    if (cmp_count_load_i && cmp_count_set_i <= ccs_pkg::CMP_COUNT_MAX) begin
      next_cmp_count = cmp_count_set_i;
    end
    // filter number is taken only from a receive that is not halted
    if (evt_i.rx_done && !halted && filter_hit_i <= ccs_pkg::HIT_MAX) begin
      next_filter_hit = filter_hit_i;
    end
    // count recessive bits; any dominant restarts the count
    if (!rx_sync) begin
      next_idle_cnt = 4'h0;
    end else if (bit_tick_i && !bus_idle) begin
      next_idle_cnt = idle_cnt + 4'h1;
    end
    if (bus_idle && !halted) begin
      next_mode_report = ccs_pkg::ccs_mode_t'(mode_request);
    end
  end

  // control registers
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      stop_idle <= 1'b0;
      abort_all <= 1'b0;
      clk_sel <= 1'b0;
      capture_en <= 1'b0;
      win_sel <= 1'b0;
      mode_request <= ccs_pkg::CCS_CONFIG;
      mode_report <= ccs_pkg::CCS_CONFIG;
      idle_cnt <= 4'h0;
      cmp_count <= 5'h00;
      fifo_start <= 5'h00;
      buf_count <= 3'h0;
      filter_hit <= 5'h00;
    end else begin
      stop_idle <= next_stop_idle;
      abort_all <= next_abort_all;
      clk_sel <= next_clk_sel;
      capture_en <= next_capture_en;
      win_sel <= next_win_sel;
      mode_request <= next_mode_request;
      mode_report <= next_mode_report;
      idle_cnt <= next_idle_cnt;
      cmp_count <= next_cmp_count;
      fifo_start <= next_fifo_start;
      buf_count <= next_buf_count;
      filter_hit <= next_filter_hit;
    end
  end

  // interrupt flags, enables, capture and read data
  always_comb begin
    evt_set = 8'h00;
    evt_set[ccs_pkg::F_IVR] = evt_i.invalid_msg;
    evt_set[ccs_pkg::F_WAK] = evt_i.wake;
    evt_set[ccs_pkg::F_ERR] = evt_i.error;
    evt_set[ccs_pkg::F_FIFO] = evt_i.fifo_almost_full;
    evt_set[ccs_pkg::F_OVF] = evt_i.rx_overflow;
    evt_set[ccs_pkg::F_RX_BUF] = evt_i.rx_done;
    evt_set[ccs_pkg::F_TB] = evt_i.tx_done;
    if (halted) begin
      evt_set = 8'h00;
    end
    next_flags = flags;
    next_enables = enables;
    next_last_code = last_code;
    if (wr_i && addr_i == ccs_pkg::ADDR_INTF) begin
      next_flags = flags & wdata_i[7:0];
    end
    if (wr_i && addr_i == ccs_pkg::ADDR_INTCLR) begin
      next_flags = flags & ~wdata_i[7:0];
    end
    next_flags = (next_flags | evt_set) & ccs_pkg::FLAG_MASK;
    if (wr_i && addr_i == ccs_pkg::ADDR_INTE) begin
      next_enables = wdata_i[7:0] & ccs_pkg::FLAG_MASK;
    end
    if (evt_set[ccs_pkg::F_RX_BUF]) begin
      next_last_code = {3'h0, evt_i.rx_buf};
    end else if (evt_set[ccs_pkg::F_TB]) begin
      next_last_code = {4'h0, evt_i.tx_buf};
    end
    next_capture = capture_en && evt_set[ccs_pkg::F_RX_BUF];
    next_rdata = 16'h0000;
    if (rd_i) begin
      case (addr_i)
        ccs_pkg::ADDR_CTRL1: begin
          next_rdata = {2'h0, stop_idle, abort_all, clk_sel, mode_request, mode_report,
                        1'b0, capture_en, 2'h0, win_sel};
        end
        ccs_pkg::ADDR_CTRL2: begin
          next_rdata = {11'h000, cmp_count};
        end
        ccs_pkg::ADDR_VEC: begin
          next_rdata = {3'h0, filter_hit, 1'b0, int_code};
        end
        ccs_pkg::ADDR_FCTRL: begin
          next_rdata = {buf_count, 8'h00, fifo_start};
        end
        ccs_pkg::ADDR_FIFO: begin
          next_rdata = {2'h0, fifo_wptr_i, 2'h0, fifo_rptr_i};
        end
        ccs_pkg::ADDR_INTF: begin
          next_rdata = {2'h0, err_i.tx_off, err_i.tx_passive, err_i.rx_passive,
                        err_i.tx_warn, err_i.rx_warn, err_i.tx_warn | err_i.rx_warn,
                        flags};
        end
        ccs_pkg::ADDR_INTE: begin
          next_rdata = {8'h00, enables};
        end
        default: begin
          next_rdata = 16'h0000;
        end
      endcase
    end
  end

  // flag and read registers
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      flags <= 8'h00;
      enables <= 8'h00;
      last_code <= 7'h00;
      capture <= 1'b0;
      rdata <= 16'h0000;
    end else begin
      flags <= next_flags;
      enables <= next_enables;
      last_code <= next_last_code;
      capture <= next_capture;
      rdata <= next_rdata;
    end
  end

  // outputs
  assign irq_o = |(flags & enables);
  assign rdata_o = rdata;
  assign capture_o = capture;
  assign mode_o = mode_report;
  assign module_run_o = !halted && (mode_report != ccs_pkg::CCS_DISABLE);
  assign abort_req_o = abort_all;
  assign clk_sel_instr_o = clk_sel;
  assign window_filter_o = win_sel;
  assign cmp_count_o = cmp_count;
  assign fifo_start_o = fifo_start;
  assign buf_count_o = buf_count;

  // checks
  chk_loop_route: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    loop_on |-> (core_rx_o == core_tx_i)) else $error("loopback route broken");
  chk_loop_pins: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    loop_on |-> pins_to_port_o && tx_pin_oe_n_o) else $error("pins not released");
  chk_idle_halt: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    (stop_idle && chip_idle_i && evt_i.rx_done && !flags[ccs_pkg::F_RX_BUF])
    |=> !flags[ccs_pkg::F_RX_BUF]) else $error("event taken in idle");
  chk_abort_clear: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    (abort_all && abort_done_i && !(wr_i && addr_i == ccs_pkg::ADDR_CTRL1 && wdata_i[ccs_pkg::BIT_ABORT]))
    |=> !abort_req_o) else $error("abort not cleared");
  chk_mode_wait: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    $changed(mode_report) |-> $past(idle_cnt) == ccs_pkg::IDLE_BITS) else $error("mode changed busy");
  chk_no_rsv_mode: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    req_ok(mode_report)) else $error("reserved mode");
  chk_cap_event: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    (capture_en && evt_i.rx_done && !halted) |=> capture_o) else $error("capture missed");
  chk_flag_set: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    (evt_i.error && !halted) |=> flags[ccs_pkg::F_ERR]) else $error("flag lost");
  chk_irq_none: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    !irq_o |-> int_code == ccs_pkg::IC_NONE) else $error("code not none");
  chk_count_range: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    cmp_count <= ccs_pkg::CMP_COUNT_MAX) else $error("invalid compare count");
  chk_hit_range: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    filter_hit <= ccs_pkg::HIT_MAX) else $error("reserved filter number");
  chk_abort_hold: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    (abort_all && !abort_done_i) |=> abort_req_o) else $error("abort dropped early");
  chk_mode_hold: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    !bus_idle |=> $stable(mode_report)) else $error("mode moved on busy bus");
  chk_req_keep: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    (wr_i && addr_i == ccs_pkg::ADDR_CTRL1 && !req_ok(wdata_i[ccs_pkg::POS_REQ +: 3]))
    |=> $stable(mode_request)) else $error("reserved request stored");
  chk_cap_off: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    !capture_en |=> !capture_o) else $error("capture while disabled");
  // flag write semantics: zero clears, one keeps
  chk_clear_zero: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    (wr_i && addr_i == ccs_pkg::ADDR_INTF && !wdata_i[ccs_pkg::F_ERR] && !evt_i.error)
    |=> !flags[ccs_pkg::F_ERR]) else $error("flag not cleared by zero");
  chk_write_keeps: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    (wr_i && addr_i == ccs_pkg::ADDR_INTF && wdata_i[ccs_pkg::F_WAK] && flags[ccs_pkg::F_WAK])
    |=> flags[ccs_pkg::F_WAK]) else $error("flag lost on write one");
  cov_loop: cover property (@(posedge ref_clk_i) disable iff (!rst_n_i) $rose(loop_on));
  cov_irq: cover property (@(posedge ref_clk_i) disable iff (!rst_n_i) $rose(irq_o));
  cov_abort: cover property (@(posedge ref_clk_i) disable iff (!rst_n_i) $fell(abort_all));
  cov_halt: cover property (@(posedge ref_clk_i) disable iff (!rst_n_i) halted && evt_i.rx_done);
  cov_mode_move: cover property (@(posedge ref_clk_i) disable iff (!rst_n_i) $changed(mode_report));
endmodule
`default_nettype wire

// [ccs_bus_node.sv]
// far-side model: other nodes on the shared bus plus the bit timer
`timescale 1ns/1ps
`default_nettype none
module ccs_bus_node #(
  parameter int BIT_CLKS = 4
) (
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic busy_i,
  input wire logic tx_pin_i,
  input wire logic tx_pin_oe_n_i,
  output logic rx_pin_o,
  output logic bit_tick_o
);
  logic [7:0] div;
  // bit timer: one tick per nominal bit time
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      div <= 8'h00;
    end else begin
      div <= (div == 8'(BIT_CLKS - 1)) ? 8'h00 : div + 8'h01;
    end
  end
  assign bit_tick_o = (div == 8'h00);
  // wired-and bus: busy nodes pull dominant, termination holds recessive
  assign rx_pin_o = !busy_i & (tx_pin_oe_n_i | tx_pin_i);
endmodule
`default_nettype wire

// [ccs_ctrl_tb.sv]
// self-checking bench for the can control, status and interrupt block
`timescale 1ns/1ps
`default_nettype none
module ccs_ctrl_tb;
  logic ref_clk_i, rst_n_i, wr_i, rd_i, core_tx_i, chip_idle_i, abort_done_i, cmp_count_load_i, bus_busy;
  logic rx_pin_i, bit_tick_i, core_rx_o, tx_pin_o, tx_pin_oe_n_o, pins_to_port_o, module_run_o;
  logic abort_req_o, clk_sel_instr_o, window_filter_o, capture_o, irq_o;
  logic [3:0] addr_i;
  logic [15:0] wdata_i, rdata_o;
  logic [4:0] cmp_count_set_i, filter_hit_i, cmp_count_o, fifo_start_o;
  logic [5:0] fifo_wptr_i, fifo_rptr_i;
  logic [2:0] buf_count_o;
  ccs_pkg::ccs_err_t err_i;
  ccs_pkg::ccs_evt_t evt_i, ev;
  ccs_pkg::ccs_mode_t mode_o;
  int errors, total_checks;
  logic [2:0] codes [6] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h7, 3'h4};

  ccs_ctrl ccs_ctrl_inst (.ref_clk_i, .rst_n_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o, .rx_pin_i,
    .core_tx_i, .core_rx_o, .tx_pin_o, .tx_pin_oe_n_o, .pins_to_port_o, .bit_tick_i, .chip_idle_i,
    .module_run_o, .abort_req_o, .abort_done_i, .clk_sel_instr_o, .window_filter_o, .cmp_count_o,
    .cmp_count_set_i, .cmp_count_load_i, .fifo_start_o, .buf_count_o, .filter_hit_i, .fifo_wptr_i,
    .fifo_rptr_i, .err_i, .evt_i, .capture_o, .mode_o, .irq_o);
  ccs_bus_node ccs_bus_node_inst (.ref_clk_i, .rst_n_i, .busy_i(bus_busy), .tx_pin_i(tx_pin_o),
    .tx_pin_oe_n_i(tx_pin_oe_n_o), .rx_pin_o(rx_pin_i), .bit_tick_o(bit_tick_i));

  // verdict and end of run
  task automatic stop_test();
    if (errors == 0 && total_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk_i);
    #1;
  endtask
  // register write: one cycle strobe
  task automatic wr(input logic [3:0] a, input logic [15:0] v);
    @(posedge ref_clk_i);
    addr_i <= a;
    wdata_i <= v;
    wr_i <= 1'b1;
    @(posedge ref_clk_i);
    wr_i <= 1'b0;
    #1;
  endtask
  // register read: data stands only in the cycle after the strobe
  task automatic rchk(input logic [3:0] a, input logic [15:0] m, input logic [15:0] exp, input string nm);
    @(posedge ref_clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge ref_clk_i);
    rd_i <= 1'b0;
    #1;
    chk(nm, exp, rdata_o & m);
  endtask
  task automatic pulse(input ccs_pkg::ccs_evt_t e);
    @(posedge ref_clk_i);
    evt_i <= e;
    @(posedge ref_clk_i);
    evt_i <= '0;
    #1;
  endtask
  // bounded wait for the reported mode
  task automatic wait_mode(input ccs_pkg::ccs_mode_t m);
    int n = 0;
    while (mode_o !== m && n < 200) begin
      cyc(1);
      n++;
    end
    chk("mode_o", 16'(m), 16'(mode_o));
    if (mode_o !== m) stop_test();
  endtask

  initial begin
    ref_clk_i = 1'b0;
    forever #25 ref_clk_i = ~ref_clk_i;
  end

  // main sequence
  initial begin
    {rst_n_i, wr_i, rd_i, chip_idle_i, abort_done_i, cmp_count_load_i, bus_busy} = '0;
    core_tx_i = 1'b1;
    addr_i = '0;
    wdata_i = '0;
    cmp_count_set_i = '0;
    filter_hit_i = '0;
    fifo_wptr_i = 6'h21;
    fifo_rptr_i = 6'h05;
    err_i = '0;
    evt_i = '0;
    errors = 0;
    total_checks = 0;
    repeat (12) @(posedge ref_clk_i);
    rst_n_i <= 1'b1;
    cyc(1);
    chk("mode_rst", 16'h0004, 16'(mode_o));
    rchk(ccs_pkg::ADDR_CTRL1, 16'hffff, 16'h0480, "ctrl1");
    rchk(ccs_pkg::ADDR_VEC, 16'hffff, 16'h0040, "vector");
    rchk(4'h9, 16'hffff, 16'h0000, "unmapped");
    // a busy bus holds off the change, then eleven idle bits allow it
    bus_busy <= 1'b1;
    cyc(8);
    wr(ccs_pkg::ADDR_CTRL1, 16'h0000);
    cyc(120);
    chk("mode_busy", 16'h0004, 16'(mode_o));
    bus_busy <= 1'b0;
    cyc(36);
    chk("mode_early", 16'h0004, 16'(mode_o));
    wait_mode(ccs_pkg::CCS_NORMAL);
    chk("oe_norm", 16'h0000, 16'(tx_pin_oe_n_o));
    foreach (codes[i]) begin
      wr(ccs_pkg::ADDR_CTRL1, {5'h00, codes[i], 8'h00});
      wait_mode(ccs_pkg::ccs_mode_t'(codes[i]));
      rchk(ccs_pkg::ADDR_CTRL1, 16'h07e0, {5'h00, codes[i], codes[i], 5'h00}, "ctrl1_mode");
      chk("to_port", 16'(codes[i] == 3'h1 || codes[i] == 3'h2), 16'(pins_to_port_o));
      chk("oe_mode", 16'(codes[i] inside {3'h1, 3'h2, 3'h3, 3'h4}), 16'(tx_pin_oe_n_o));
    end
    // loopback ignores the pin, reserved code leaves the request alone
    wr(ccs_pkg::ADDR_CTRL1, 16'h0200);
    wait_mode(ccs_pkg::CCS_LOOP);
    bus_busy <= 1'b1;
    cyc(6);
    chk("loop_hi", 16'h0001, 16'(core_rx_o));
    core_tx_i <= 1'b0;
    cyc(1);
    chk("loop_lo", 16'h0000, 16'(core_rx_o));
    chk("tx_pin", 16'h0000, 16'(tx_pin_o));
    chk("oe_loop", 16'h0001, 16'(tx_pin_oe_n_o));
    core_tx_i <= 1'b1;
    bus_busy <= 1'b0;
    wr(ccs_pkg::ADDR_CTRL1, 16'h0500);
    cyc(60);
    rchk(ccs_pkg::ADDR_CTRL1, 16'h07e0, 16'h0240, "reserved");
    // control bits, idle stop and capture
    wr(ccs_pkg::ADDR_CTRL1, 16'h2c09);
    chk("clk_sel", 16'h0001, 16'(clk_sel_instr_o));
    chk("window", 16'h0001, 16'(window_filter_o));
    chk("run", 16'h0001, 16'(module_run_o));
    chip_idle_i <= 1'b1;
    cyc(1);
    chk("halt", 16'h0000, 16'(module_run_o));
    ev = '0;
    ev.rx_done = 1'b1;
    pulse(ev);
    chk("cap_halt", 16'h0000, 16'(capture_o));
    chip_idle_i <= 1'b0;
    filter_hit_i <= 5'h0f;
    pulse(ev);
    chk("capture", 16'h0001, 16'(capture_o));
    filter_hit_i <= 5'h10;
    pulse(ev);
    rchk(ccs_pkg::ADDR_VEC, 16'h1f00, 16'h0f00, "hit_num");
    wr(ccs_pkg::ADDR_CTRL1, 16'h0400);
    chk("clk_osc", 16'h0000, 16'(clk_sel_instr_o));
    chk("window_buf", 16'h0000, 16'(window_filter_o));
    pulse(ev);
    chk("cap_off", 16'h0000, 16'(capture_o));
    // abort clears itself once buffers report done
    wr(ccs_pkg::ADDR_CTRL1, 16'h1400);
    chk("abort", 16'h0001, 16'(abort_req_o));
    abort_done_i <= 1'b1;
    cyc(2);
    abort_done_i <= 1'b0;
    cyc(1);
    rchk(ccs_pkg::ADDR_CTRL1, 16'h1000, 16'h0000, "abort_clr");
    // compare count, fifo control and status, error state
    cmp_count_set_i <= 5'h11;
    cmp_count_load_i <= 1'b1;
    cyc(1);
    cmp_count_set_i <= 5'h12;
    cyc(1);
    cmp_count_load_i <= 1'b0;
    rchk(ccs_pkg::ADDR_CTRL2, 16'hffff, 16'h0011, "cmp_count");
    chk("cmp_count_o", 16'h0011, 16'(cmp_count_o));
    wr(ccs_pkg::ADDR_FCTRL, 16'he01f);
    rchk(ccs_pkg::ADDR_FCTRL, 16'hffff, 16'he01f, "fctrl");
    chk("fifo_start", 16'h001f, 16'(fifo_start_o));
    chk("buf_count", 16'h0007, 16'(buf_count_o));
    rchk(ccs_pkg::ADDR_FIFO, 16'hffff, 16'h2105, "fifo_stat");
    err_i <= 5'b00010;
    rchk(ccs_pkg::ADDR_INTF, 16'h3f00, 16'h0500, "err_warn");
    err_i <= 5'b11111;
    rchk(ccs_pkg::ADDR_INTF, 16'h3f00, 16'h3f00, "err_all");
    // flags, enables, priority and clearing
    wr(ccs_pkg::ADDR_INTCLR, 16'h00ff);
    wr(ccs_pkg::ADDR_INTE, 16'h00ef);
    rchk(ccs_pkg::ADDR_INTE, 16'hffff, 16'h00ef, "inte");
    ev = '0;
    ev.error = 1'b1;
    ev.wake = 1'b1;
    pulse(ev);
    rchk(ccs_pkg::ADDR_INTF, 16'h00ff, 16'h0060, "flags");
    chk("irq_on", 16'h0001, 16'(irq_o));
    rchk(ccs_pkg::ADDR_VEC, 16'h007f, 16'(ccs_pkg::IC_ERR), "code_err");
    wr(ccs_pkg::ADDR_INTF, 16'h00ff);
    rchk(ccs_pkg::ADDR_INTF, 16'h00ff, 16'h0060, "write_one");
    wr(ccs_pkg::ADDR_INTF, 16'h00df);
    rchk(ccs_pkg::ADDR_VEC, 16'h007f, 16'(ccs_pkg::IC_WAK), "code_wak");
    wr(ccs_pkg::ADDR_INTE, 16'h00af);
    chk("irq_mask", 16'h0000, 16'(irq_o));
    wr(ccs_pkg::ADDR_INTE, 16'h00ef);
    wr(ccs_pkg::ADDR_INTF, 16'h0000);
    rchk(ccs_pkg::ADDR_VEC, 16'h007f, 16'(ccs_pkg::IC_NONE), "code_none");
    chk("irq_off", 16'h0000, 16'(irq_o));
    ev = '0;
    ev.rx_done = 1'b1;
    ev.rx_buf = 4'h9;
    pulse(ev);
    rchk(ccs_pkg::ADDR_VEC, 16'h007f, 16'h0009, "code_rb9");
    ev = '0;
    ev.rx_overflow = 1'b1;
    ev.fifo_almost_full = 1'b1;
    ev.invalid_msg = 1'b1;
    pulse(ev);
    rchk(ccs_pkg::ADDR_VEC, 16'h007f, 16'(ccs_pkg::IC_OVF), "code_ovf");
    wr(ccs_pkg::ADDR_INTCLR, 16'h0004);
    rchk(ccs_pkg::ADDR_VEC, 16'h007f, 16'(ccs_pkg::IC_FIFO), "code_fifo");
    rchk(ccs_pkg::ADDR_INTF, 16'h00ff, 16'h008a, "flags_set");
    stop_test();
  end
endmodule
`default_nettype wire
